// >>> sdr_params.svh
`ifndef SDR_PARAMS_SVH
`define SDR_PARAMS_SVH
`define SDR_NCH        10
`define SDR_CODE_OK    2'h3
`define SDR_FRAME_BITS 5'h10
`define SDR_HALF_BITS  5'h08
`define SDR_LAST_IDX   4'hf
`define SDR_CMD_BANK_A 4'h2
`define SDR_CMD_BANK_B 4'h3
`define SDR_COMBO_HDR  3'h0
`define SDR_SEL_DIAG1  5'h11
`define SDR_SEL_DIAG2  5'h12
`define SDR_SEL_DIAG3  5'h13
`define SDR_BANK_TAG   3'h1
`define SDR_ONES2      2'h3
`define SDR_ZERO4      4'h0
`define SDR_MODE_RESET 4'hf
`define SDR_ON_RESET   4'h0
`define SDR_SPI_IDLE   3'h4
`define SDR_PIN_IDLE   4'h0
`endif

// >>> sdr_pkg.sv
package sdr_pkg;
  // Frame tracking, one-hot
  typedef enum logic [1:0] {
    SDR_ST_IDLE  = 2'b01,
    SDR_ST_FRAME = 2'b10
  } sdr_state_e;
  // What the previous complete frame asked to have returned
  typedef enum logic [3:0] {
    SDR_RESP_NONE  = 4'b0001,
    SDR_RESP_COMBO = 4'b0010,
    SDR_RESP_BANKA = 4'b0100,
    SDR_RESP_BANKB = 4'b1000
  } sdr_resp_e;
endpackage

// >>> sdr_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for pin inputs
module sdr_sync #(
  parameter int unsigned  W         = 1,      // Bits to synchronise
  parameter logic [W-1:0] RESET_VAL = '0      // Idle level held in reset
) (
  input  wire logic         sys_clk,          // System clock
  input  wire logic         rst_n,            // Reset, active low
  input  wire logic [W-1:0] async_in,         // Pin levels
  output logic      [W-1:0] sync_out          // Synchronised levels
);
  logic [W-1:0] meta_reg;                     // First stage, only read below
  logic [W-1:0] meta_next;                    // Next first stage
  logic [W-1:0] sync_next;                    // Next second stage

  // Next values; first stage feeds second stage only
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // Both stages reset to the pins' idle level, so that no false edge
  // reaches the edge detectors in the cycles after reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= meta_next;
      sync_out <= sync_next;
    end
  end
endmodule // sdr_sync

// >>> sdr_top.sv
`timescale 1ns/10ps
`include "sdr_params.svh"
// Diagnosis storage with SPI readout and pin-set commands
module sdr_top (
  input  wire logic        sys_clk,           // 10 MHz system clock
  input  wire logic        arst_n,            // Async reset, active low
  input  wire logic        spi_cs_n,          // SPI chip select pin
  input  wire logic        spi_sck,           // SPI clock pin
  input  wire logic        spi_si,            // SPI serial in pin
  output logic             spi_so,            // SPI serial out data
  output logic             spi_so_oe_n,       // SO enable, low drives
  input  wire logic [9:0]  fault_event,       // Per channel new fault pulse
  input  wire logic [19:0] fault_code_in,     // Per channel new code
  input  wire logic [3:0]  par_in,            // Input pins ch7..ch10
  output logic [3:0]       ch_parallel,       // Ch7..10 parallel mode
  output logic [3:0]       ch_serial_on       // Ch7..10 serial on state
);
  logic        rst_meta_reg;                  // Reset release stage one
  logic        rst_n;                         // Synchronised reset
  logic [2:0]  spi_s;                         // Synced cs_n, sck, si
  logic [3:0]  par_s;                         // Synced input pins
  logic        cs_n_s;                        // Synced chip select
  logic        sck_s;                         // Synced clock
  logic        si_s;                          // Synced data
  logic        cs_d_reg;                      // Previous chip select
  logic        sck_d_reg;                     // Previous clock
  logic        cs_fall;                       // Frame start
  logic        cs_rise;                       // Frame end
  logic        sck_rise;                      // Sample edge
  logic        sck_fall;                      // Drive edge
  logic [19:0] code_reg;                      // Stored fault codes
  logic [19:0] code_next;                     // Next fault codes
  logic [19:0] snap_reg;                      // Codes captured at cs fall
  logic [19:0] snap_next;                     // Next capture
  sdr_pkg::sdr_state_e st_reg;                // Frame state
  sdr_pkg::sdr_state_e st_next;               // Next frame state
  sdr_pkg::sdr_resp_e  resp_reg;              // Pending answer kind
  sdr_pkg::sdr_resp_e  resp_next;             // Next answer kind
  logic [4:0]  cnt_reg;                       // Bits received
  logic [4:0]  cnt_next;                      // Next bit count
  logic [3:0]  idx_reg;                       // Bit being driven
  logic [3:0]  idx_next;                      // Next driven bit
  logic [15:0] rx_reg;                        // Received shift register
  logic [15:0] rx_next;                       // Next received bits
  logic [15:0] tx_reg;                        // Word being returned
  logic [15:0] tx_next;                       // Next returned word
  logic [3:0]  mode_next;                     // Next parallel modes
  logic [3:0]  on_next;                       // Next serial on bits
  logic        so_next;                       // Next SO bit
  logic [7:0]  diag1;                         // Diagnosis byte one
  logic [7:0]  diag2;                         // Diagnosis byte two
  logic [7:0]  diag3;                         // Diagnosis byte three
  logic [11:0] bank_low;                      // Bank of channels 1..6
  logic [11:0] bank_high;                     // Bank of channels 7..10
  logic [7:0]  pin_feedback_byte;             // Pin feedback byte
  logic [14:0] bank_body;                     // Bank frame below parity
  logic [7:0]  up_byte;                       // Upper byte, mid frame
  logic [4:0]  diag_select;                   // Selector, mid frame
  logic [3:0]  any_bad;                       // Per channel pair fault flags

  // Reset release through two flops; assert is immediate
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Pins cross into the clock domain through two flops each
  // Chip select idles high, so its stages reset high
  sdr_sync #(.W(3), .RESET_VAL(`SDR_SPI_IDLE)) u_spi_sync (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .async_in  ({spi_cs_n, spi_sck, spi_si}),
    .sync_out  (spi_s)
  );
  sdr_sync #(.W(4), .RESET_VAL(`SDR_PIN_IDLE)) u_pin_sync (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .async_in  (par_in),
    .sync_out  (par_s)
  );

  assign cs_n_s   = spi_s[2];
  assign sck_s    = spi_s[1];
  assign si_s     = spi_s[0];
  // Edges; sck needs several system clocks per phase to be seen
  assign cs_fall  = cs_d_reg & ~cs_n_s;
  assign cs_rise  = ~cs_d_reg & cs_n_s;
  assign sck_rise = ~sck_d_reg & sck_s & ~cs_n_s;
  assign sck_fall = sck_d_reg & ~sck_s & ~cs_n_s;

  // Fault storage, newest event overwrites
  genvar g;
  generate
    for (g = 0; g < `SDR_NCH; g++) begin : g_ch
      always_comb begin
        if (fault_event[g]) begin
          code_next[2*g+1:2*g] = fault_code_in[2*g+1:2*g];
        end else begin
          code_next[2*g+1:2*g] = code_reg[2*g+1:2*g];
        end
      end
    end
  endgenerate

  // Summary flags per group, fault is any code other than ok
  always_comb begin
    any_bad[0] = (snap_reg[1:0]   != `SDR_CODE_OK) |
                 (snap_reg[3:2]   != `SDR_CODE_OK);
    any_bad[1] = (snap_reg[5:4]   != `SDR_CODE_OK) |
                 (snap_reg[7:6]   != `SDR_CODE_OK);
    any_bad[2] = (snap_reg[13:12] != `SDR_CODE_OK) |
                 (snap_reg[15:14] != `SDR_CODE_OK);
    any_bad[3] = (snap_reg[17:16] != `SDR_CODE_OK) |
                 (snap_reg[19:18] != `SDR_CODE_OK);
  end

  // Diagnosis bytes from the frame snapshot, banks from the live codes
  assign diag1     = snap_reg[7:0];
  assign diag3     = snap_reg[19:12];
  assign diag2     = {any_bad[0] | any_bad[1], any_bad[2] | any_bad[3],
                      `SDR_ONES2, snap_reg[11:8]};
  assign bank_low  = code_reg[11:0];
  assign bank_high = {`SDR_ZERO4, code_reg[19:12]};
  // Feedback per channel: pin level if parallel, echo if serial
  assign pin_feedback_byte = {(ch_parallel & par_s) |
                              (~ch_parallel & ch_serial_on),
                              ch_parallel};
  assign up_byte     = rx_reg[7:0];
  assign diag_select = up_byte[4:0];

  // Bank body selected from the pending answer kind
  always_comb begin
    if (resp_reg == sdr_pkg::SDR_RESP_BANKB) begin
      bank_body = {`SDR_BANK_TAG, bank_high};
    end else begin
      bank_body = {`SDR_BANK_TAG, bank_low};
    end
  end

  // Frame engine next values
  always_comb begin
    st_next   = st_reg;
    resp_next = resp_reg;
    cnt_next  = cnt_reg;
    idx_next  = idx_reg;
    rx_next   = rx_reg;
    tx_next   = tx_reg;
    snap_next = snap_reg;
    mode_next = ch_parallel;
    on_next   = ch_serial_on;
    unique case (st_reg)
      sdr_pkg::SDR_ST_IDLE: begin
        if (cs_fall) begin
          st_next   = sdr_pkg::SDR_ST_FRAME;
          cnt_next  = 5'h00;
          idx_next  = 4'h0;
          snap_next = code_reg;
          // Combo upper byte answers the previous frame's lower byte; a bank answer fills all 16 bits
          unique case (resp_reg)
            sdr_pkg::SDR_RESP_COMBO:
              tx_next = {pin_feedback_byte, 8'h00};
            sdr_pkg::SDR_RESP_BANKA,
            sdr_pkg::SDR_RESP_BANKB:
              tx_next = {^bank_body, bank_body};
            sdr_pkg::SDR_RESP_NONE:
              tx_next = 16'h0000;
          endcase
        end
      end
      sdr_pkg::SDR_ST_FRAME: begin
        if (sck_rise && cnt_reg != `SDR_FRAME_BITS) begin
          rx_next  = {rx_reg[14:0], si_s};
          cnt_next = cnt_reg + 5'h01;
        end
        if (sck_fall && idx_reg != `SDR_LAST_IDX) begin
          idx_next = idx_reg + 4'h1;
        end
        // Lower byte is settled before its first bit is driven
        if (cnt_reg == `SDR_HALF_BITS &&
            up_byte[7:5] == `SDR_COMBO_HDR) begin
          unique case (diag_select)
            `SDR_SEL_DIAG1: tx_next[7:0] = diag1;
            `SDR_SEL_DIAG2: tx_next[7:0] = diag2;
            `SDR_SEL_DIAG3: tx_next[7:0] = diag3;
            default:        tx_next[7:0] = tx_reg[7:0];
          endcase
        end
        if (cs_rise) begin
          st_next   = sdr_pkg::SDR_ST_IDLE;
          resp_next = sdr_pkg::SDR_RESP_NONE;
          // Short frames are discarded and answer nothing; long frames keep their first 16 bits
          if (cnt_reg == `SDR_FRAME_BITS) begin
            if (rx_reg[15:13] == `SDR_COMBO_HDR &&
                (rx_reg[12:8] == `SDR_SEL_DIAG1 ||
                 rx_reg[12:8] == `SDR_SEL_DIAG2 ||
                 rx_reg[12:8] == `SDR_SEL_DIAG3)) begin
              resp_next = sdr_pkg::SDR_RESP_COMBO;
              mode_next = rx_reg[3:0];
              on_next   = rx_reg[7:4];
            end else if (rx_reg[15:12] == `SDR_CMD_BANK_A) begin
              resp_next = sdr_pkg::SDR_RESP_BANKA;
            end else if (rx_reg[15:12] == `SDR_CMD_BANK_B) begin
              resp_next = sdr_pkg::SDR_RESP_BANKB;
            end
          end
        end
      end
    endcase
    so_next = tx_reg[`SDR_LAST_IDX - idx_reg];
  end

  // Registers of the frame engine and fault store
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg     <= {`SDR_NCH{`SDR_CODE_OK}};
      snap_reg     <= {`SDR_NCH{`SDR_CODE_OK}};
      st_reg       <= sdr_pkg::SDR_ST_IDLE;
      resp_reg     <= sdr_pkg::SDR_RESP_NONE;
      cnt_reg      <= 5'h00;
      idx_reg      <= 4'h0;
      rx_reg       <= 16'h0000;
      tx_reg       <= 16'h0000;
      cs_d_reg     <= 1'b1;
      sck_d_reg    <= 1'b0;
      ch_parallel  <= `SDR_MODE_RESET;
      ch_serial_on <= `SDR_ON_RESET;
      spi_so       <= 1'b0;
      spi_so_oe_n  <= 1'b1;
    end else begin
      code_reg     <= code_next;
      snap_reg     <= snap_next;
      st_reg       <= st_next;
      resp_reg     <= resp_next;
      cnt_reg      <= cnt_next;
      idx_reg      <= idx_next;
      rx_reg       <= rx_next;
      tx_reg       <= tx_next;
      cs_d_reg     <= cs_n_s;
      sck_d_reg    <= sck_s;
      ch_parallel  <= mode_next;
      ch_serial_on <= on_next;
      spi_so       <= so_next;
      spi_so_oe_n  <= cs_n_s;
    end
  end
endmodule // sdr_top

// >>> sdr_top_asserts.sv
`timescale 1ns/10ps
// Port checks on the readout; sync delay of two to four clocks is allowed
module sdr_top_asserts (
  input wire logic        sys_clk,       // Clock
  input wire logic        arst_n,        // Reset, active low
  input wire logic        spi_cs_n,      // Chip select pin
  input wire logic        spi_sck,       // Serial clock pin
  input wire logic        spi_si,        // Serial in pin
  input wire logic        spi_so,        // Serial out
  input wire logic        spi_so_oe_n,   // SO enable, low drives
  input wire logic [9:0]  fault_event,   // Fault pulses
  input wire logic [19:0] fault_code_in, // Fault codes
  input wire logic [3:0]  par_in,        // Input pins
  input wire logic [3:0]  ch_parallel,   // Channel modes
  input wire logic [3:0]  ch_serial_on   // Serial on states
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Pins come out of reset parallel and off
  pin_reset_a: assert property ($rose(arst_n) |->
    ch_parallel == 4'hf && ch_serial_on == 4'h0) else $error("pin reset");
  oe_on_a: assert property ($fell(spi_cs_n) |-> ##[2:4] !spi_so_oe_n)
    else $error("SO not driven after select");
  oe_off_a: assert property ($rose(spi_cs_n) |-> ##[2:4] spi_so_oe_n)
    else $error("SO not released");
  oe_idle_a: assert property (spi_cs_n [*5] |-> spi_so_oe_n)
    else $error("SO driven while idle");
  // Driving needs a select seen through the synchroniser
  oe_cause_a: assert property (!spi_so_oe_n |->
    !$past(spi_cs_n, 3) || !$past(spi_cs_n, 4)) else $error("SO no cause");
  // A new bit only follows a clock low phase
  so_hold_a: assert property (!spi_so_oe_n && !$past(spi_so_oe_n)
    && $changed(spi_so) |-> !$past(spi_sck, 1) && !$past(spi_sck, 2))
    else $error("SO moved in high phase");
  pins_hold_a: assert property (!spi_cs_n [*8] |->
    $stable(ch_parallel) && $stable(ch_serial_on)) else $error("pins moved");
  pins_when_a: assert property ($changed(ch_parallel)
    || $changed(ch_serial_on) |-> $past(spi_cs_n, 1) && $past(spi_cs_n, 2))
    else $error("pins moved outside frame end");
  cover property ($rose(spi_cs_n));
  cover property ($changed(ch_parallel));
  cover property (!spi_so_oe_n && spi_so);
endmodule // sdr_top_asserts

bind sdr_top sdr_top_asserts u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si),
  .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n), .fault_event(fault_event),
  .fault_code_in(fault_code_in), .par_in(par_in),
  .ch_parallel(ch_parallel), .ch_serial_on(ch_serial_on));

// >>> sdr_host_model.sv
`timescale 1ns/10ps
// Host controller as SPI master, mode 0, clock parked low between frames
module sdr_host_model #(
  parameter int PH = 5            // Clocks per sck phase, at least four
) (
  input  wire logic sys_clk,      // System clock
  output logic      spi_cs_n,     // Chip select
  output logic      spi_sck,      // Serial clock
  output logic      spi_si,       // Data to device
  input  wire logic spi_so        // Data from device
);
  // Idle and deselected
  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_si = 1'b0;
  end
  // One whole frame, selector high byte, pin byte low
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    @(negedge sys_clk);
    spi_cs_n = 1'b0;
    for (i = 15; i >= 0; i--) begin
      spi_si = tx[i];
      repeat (PH) @(negedge sys_clk);
      spi_sck = 1'b1;
      rx[i] = spi_so;
      repeat (PH) @(negedge sys_clk);
      spi_sck = 1'b0;
    end
    repeat (PH) @(negedge sys_clk);
    spi_cs_n = 1'b1;
    spi_si = ~spi_si; // Stale data must not pass for valid
    repeat (6) @(negedge sys_clk);
  endtask
endmodule // sdr_host_model

// >>> spi_diagnosis_readout_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the diagnosis readout
module spi_diagnosis_readout_tb;
  localparam logic [19:0] CODES = 20'hb16e4; // Every code, ch10 first
  logic        sys_clk, arst_n;         // Clock and reset
  logic        spi_cs_n, spi_sck, spi_si; // Host pins
  logic        spi_so, spi_so_oe_n;     // Device serial out
  logic [9:0]  fault_event;             // Fault pulses
  logic [19:0] fault_code_in;           // Fault codes
  logic [3:0]  par_in, ch_parallel, ch_serial_on; // Channel pins
  logic [19:0] codes;                   // Expected stored codes
  logic [15:0] r;                       // Last frame received
  int          n_mismatch, checked;     // Counters

  sdr_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck), .spi_si(spi_si), .spi_so(spi_so),
    .spi_so_oe_n(spi_so_oe_n), .fault_event(fault_event),
    .fault_code_in(fault_code_in), .par_in(par_in),
    .ch_parallel(ch_parallel), .ch_serial_on(ch_serial_on));
  sdr_host_model host (.sys_clk(sys_clk), .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck), .spi_si(spi_si), .spi_so(spi_so));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  // Parity makes the whole word even
  function automatic logic [15:0] bank_word(input logic [11:0] b);
    return {^{3'h1, b}, 3'h1, b};
  endfunction
  function automatic logic [7:0] diag2(input logic [19:0] c);
    return {c[7:0] != 8'hff, c[19:12] != 8'hff, 2'h3, c[11:8]};
  endfunction
  // One-cycle fault pulse; the model follows the overwrite
  task automatic inject(input int ch, input logic [1:0] c);
    @(negedge sys_clk);
    fault_event[ch] = 1'b1;
    fault_code_in[2*ch +: 2] = c;
    codes[2*ch +: 2] = c;
    @(negedge sys_clk);
    fault_event = 10'h000;
  endtask

  task automatic t_reset_state;
    chk("pins", 16'h00f0, {8'h00, ch_parallel, ch_serial_on});
    host.xfer(16'h1200, r);
    chk("diag two", 16'h003f, r);
    host.xfer(16'h2000, r);
    chk("no answer", 16'h0000, r);
    host.xfer(16'h3000, r);
    chk("bank low", bank_word(12'hfff), r);
    host.xfer(16'h0000, r);
    chk("bank high", bank_word(12'h0ff), r);
  endtask

  task automatic t_fault_codes;
    logic [15:0] w;
    inject(0, 2'h2);
    for (int ch = 0; ch < 10; ch++) inject(ch, CODES[2*ch +: 2]);
    host.xfer(16'h2000, r);
    host.xfer(16'h3000, r);
    chk("bank low", bank_word(codes[11:0]), r);
    w = bank_word({4'h0, codes[19:12]});
    host.xfer(16'h1100, r);
    chk("diag one", {w[15:8], codes[7:0]}, r);
    host.xfer(16'h1300, r);
    chk("diag three", {8'h00, codes[19:12]}, r);
    host.xfer(16'h1200, r);
    chk("diag two", {8'h00, diag2(codes)}, r);
  endtask

  // Mixed modes: serial echoes sent bits, parallel shows the pins
  task automatic t_pins;
    par_in = 4'h6;
    host.xfer(16'h135a, r);
    chk("diag three", {8'h00, codes[19:12]}, r);
    chk("pins", 16'h00a5, {8'h00, ch_parallel, ch_serial_on});
    host.xfer(16'h110f, r);
    chk("feedback", {8'h7a, codes[7:0]}, r);
    host.xfer(16'h1200, r);
    chk("feedback", {8'h6f, diag2(codes)}, r);
    host.xfer(16'h0000, r);
    chk("refused", 16'h0000, r);
  endtask

  // A fault mid-frame must wait for the next frame
  task automatic t_snapshot;
    logic [7:0] old;
    old = codes[7:0];
    fork
      host.xfer(16'h1100, r);
      begin
        repeat (30) @(negedge sys_clk);
        inject(0, 2'h2);
      end
    join
    chk("snapshot", {8'h00, old}, r);
    host.xfer(16'h1100, r);
    chk("new code", {8'h00, codes[7:0]}, r);
  endtask

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    fault_event = 10'h000;
    fault_code_in = 20'h00000;
    par_in = 4'h0;
    codes = 20'hfffff;
    n_mismatch = 0;
    checked = 0;
    repeat (2) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    t_reset_state();
    t_fault_codes();
    t_pins();
    t_snapshot();
    complete_run();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    complete_run();
  end
endmodule // spi_diagnosis_readout_tb
